// [design/pfc_checker.sv]
// Parameter and run-time fault checker for one loop
`timescale 1ns/100ps
`include "pfc_defs.svh"
// Summary of operation
// - Error 0001 when maximum manipulated value is below minimum.
// - Error 0002 when maximum process value is below minimum.
// - Error 0003 when PWM output period is below 100 units while tuning or running.
// - Error 0004 when tuning starts with set value on the wrong side.
// - Error 0005 when PWM output point lies outside 20h to 3Fh.
// - Error 0006 when proportional gain is negative.
// - Error 0007 when integral time is negative.
// - Error 0008 when differential time is negative.
// - Error 0009 when control mode is not P, PI, PD or PID.
// - Error 000A when direction changes while tuning runs.
// - Error 000B when operation period is below 100 units while tuning or running.
// - Error 000C when a mixed loop has the wrong direction.
// - Error 000D when mixed loops have unequal set values.
// - Warning 0001 when process value is outside its bounds.
// - Warning 0002 when operation cycle is not longer than scan time.
// - Warning 0003 when process value step exceeds its change limit.
// - Warning 0004 when manipulated value step exceeds its change limit.
// - Warning 0005 when computed manipulated value exceeds maximum.
// - Warning 0006 when computed manipulated value is below minimum.
// - Tuning error flag rises whenever tuning meets an error.
module pfc_checker
    import pfc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic signed [15:0] i_mv_max,
    input wire logic signed [15:0] i_mv_min,
    input wire logic signed [15:0] i_pv_max,
    input wire logic signed [15:0] i_pv_min,
    input wire logic [15:0] i_out_period,
    input wire logic [15:0] i_op_period,
    input wire logic [15:0] i_scan_time,
    input wire logic i_pwm_en,
    input wire logic [7:0] i_pwm_point,
    input wire logic signed [15:0] i_p_gain,
    input wire logic signed [15:0] i_i_time,
    input wire logic signed [15:0] i_d_time,
    input wire logic [2:0] i_mode,
    input wire logic i_dir_reverse,
    input wire logic i_mixed,
    input wire logic i_mixed_expect_reverse,
    input wire logic signed [15:0] i_set_value,
    input wire logic signed [15:0] i_partner_set_value,
    input wire logic signed [15:0] i_process_value,
    input wire logic [15:0] i_pv_slew_limit,
    input wire logic [15:0] i_mv_slew_limit,
    input wire logic signed [15:0] i_mv_calc,
    input wire logic signed [15:0] i_mv_prev,
    input wire logic i_cycle,
    input wire logic i_tune_start,
    input wire logic i_tune_done,
    input wire logic i_run_start,
    input wire logic i_stop,
    input wire logic i_clear,
    output logic [15:0] o_err_code,
    output logic [15:0] o_warn_code,
    output logic o_tune_err,
    output logic o_tuning,
    output logic o_running
);

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] absdiff(input logic signed [15:0] a,
                                            input logic signed [15:0] b);
        logic signed [16:0] d;
        d = 17'(a) - 17'(b);
        absdiff = d[16] ? 16'(-d) : d[15:0];
        if (d[16] ? (-d) > 17'sh0FFFF : d > 17'sh0FFFF) begin
            absdiff = 16'hFFFF;
        end
    endfunction

    pfc_regs_t r_ff;
    pfc_regs_t nxt_r;
    logic [15:0] static_err;
    logic [15:0] cyc_warn;
    logic active;
    logic side_bad;

    ////////////////////////////////////////////////////////////////////
    // Static settings check, lowest code has priority
    always_comb begin
        active = (r_ff.state != PFC_IDLE);
        static_err = `PFC_ERR_NONE;
        if (i_mixed && (i_set_value != i_partner_set_value)) begin
            static_err = `PFC_ERR_MIX_SV;
        end
        if (i_mixed && (i_dir_reverse != i_mixed_expect_reverse)) begin
            static_err = `PFC_ERR_MIX_DIR;
        end
        if (active && (i_op_period < `PFC_MIN_PERIOD)) begin
            static_err = `PFC_ERR_LOOP_PERIOD;
        end
        if (i_mode > 3'(PFC_MODE_PID)) begin
            static_err = `PFC_ERR_MODE;
        end
        if (i_d_time < $signed(`PFC_ZERO)) begin
            static_err = `PFC_ERR_D_TIME;
        end
        if (i_i_time < $signed(`PFC_ZERO)) begin
            static_err = `PFC_ERR_I_TIME;
        end
        if (i_p_gain < $signed(`PFC_ZERO)) begin
            static_err = `PFC_ERR_P_GAIN;
        end
        if (i_pwm_en && ((i_pwm_point < `PFC_PWM_LO) || (i_pwm_point > `PFC_PWM_HI))) begin
            static_err = `PFC_ERR_PWM_POINT;
        end
        if (active && i_pwm_en && (i_out_period < `PFC_MIN_PERIOD)) begin
            static_err = `PFC_ERR_OUT_PERIOD;
        end
        if (i_pv_max < i_pv_min) begin
            static_err = `PFC_ERR_IN_ORDER;
        end
        if (i_mv_max < i_mv_min) begin
            static_err = `PFC_ERR_OUT_ORDER;
        end
    end

    // Forward needs set value not above process value, reverse the mirror
    assign side_bad = i_dir_reverse ? (i_set_value < i_process_value)
                                    : (i_set_value > i_process_value);

    ////////////////////////////////////////////////////////////////////
    // Per-cycle warnings, lowest code has priority
    always_comb begin
        cyc_warn = `PFC_ERR_NONE;
        if (i_mv_calc < i_mv_min) begin
            cyc_warn = `PFC_WRN_OUT_LOW;
        end
        if (i_mv_calc > i_mv_max) begin
            cyc_warn = `PFC_WRN_OUT_HIGH;
        end
        if (absdiff(i_mv_calc, i_mv_prev) > i_mv_slew_limit) begin
            cyc_warn = `PFC_WRN_OUT_SLEW;
        end
        if (r_ff.prev_pv_ok && (absdiff(i_process_value, r_ff.prev_pv) > i_pv_slew_limit)) begin
            cyc_warn = `PFC_WRN_IN_SLEW;
        end
        if (i_op_period <= i_scan_time) begin
            cyc_warn = `PFC_WRN_CYCLE_SHORT;
        end
        if ((i_process_value > i_pv_max) || (i_process_value < i_pv_min)) begin
            cyc_warn = `PFC_WRN_IN_BOUNDS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_r = r_ff;
        case (r_ff.state)
            PFC_IDLE: begin
                if (i_tune_start) begin
                    nxt_r.state = PFC_TUNING;
                    nxt_r.tune_dir = i_dir_reverse;
                    nxt_r.tune_err = 1'b0;
                end else if (i_run_start) begin
                    // Loop gains expected to hold tuned values by now
                    nxt_r.state = PFC_RUNNING;
                end
            end
            PFC_TUNING: begin
                if (i_stop || i_tune_done) begin
                    nxt_r.state = PFC_IDLE;
                end
            end
            PFC_RUNNING: begin
                if (i_stop) begin
                    nxt_r.state = PFC_IDLE;
                end
            end
            default: begin
                nxt_r.state = PFC_IDLE;
            end
        endcase
        if (nxt_r.state == PFC_IDLE) begin
            nxt_r.prev_pv_ok = 1'b0;
        end
        // Clear first so a fresh fault in the same cycle wins
        if (i_clear) begin
            nxt_r.err_code = `PFC_ERR_NONE;
            nxt_r.warn_code = `PFC_ERR_NONE;
            nxt_r.tune_err = 1'b0;
        end else if ((static_err == `PFC_ERR_NONE) && (r_ff.err_code != `PFC_ERR_TUNE_DIR)
                     && (r_ff.err_code != `PFC_ERR_SETPOINT_SIDE)) begin
            nxt_r.err_code = `PFC_ERR_NONE;
        end
        if (static_err != `PFC_ERR_NONE) begin
            nxt_r.err_code = static_err;
        end
        if ((r_ff.state == PFC_IDLE) && i_tune_start && side_bad) begin
            nxt_r.err_code = `PFC_ERR_SETPOINT_SIDE;
        end
        if ((r_ff.state == PFC_TUNING) && (i_dir_reverse != r_ff.tune_dir)) begin
            nxt_r.err_code = `PFC_ERR_TUNE_DIR;
        end
        if ((r_ff.state != PFC_RUNNING) && (nxt_r.state == PFC_TUNING)
            && (nxt_r.err_code != `PFC_ERR_NONE)) begin
            nxt_r.tune_err = 1'b1;
        end
        if ((r_ff.state == PFC_TUNING) && (nxt_r.err_code != `PFC_ERR_NONE)) begin
            nxt_r.tune_err = 1'b1;
        end
        if (active && i_cycle) begin
            nxt_r.warn_code = cyc_warn;
            nxt_r.prev_pv = i_process_value;
            nxt_r.prev_pv_ok = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r_ff <= '{state: PFC_IDLE, default: '0};
        end else if (i_ce) begin
            r_ff <= nxt_r;
        end
    end

    assign o_err_code = r_ff.err_code;
    assign o_warn_code = r_ff.warn_code;
    assign o_tune_err = r_ff.tune_err;
    assign o_tuning = (r_ff.state == PFC_TUNING);
    assign o_running = (r_ff.state == PFC_RUNNING);

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_out_order;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && (i_mv_max < i_mv_min) && !(r_ff.state == PFC_TUNING && i_dir_reverse != r_ff.tune_dir)
         && !(r_ff.state == PFC_IDLE && i_tune_start && side_bad))
        |=> (o_err_code == `PFC_ERR_OUT_ORDER);
    endproperty
    a_out_order: assert property (p_out_order) else $error("out order");

    property p_in_order;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && (i_pv_max < i_pv_min) && !(i_mv_max < i_mv_min) && !i_tune_start
         && !(r_ff.state == PFC_TUNING)) |=> (o_err_code == `PFC_ERR_IN_ORDER);
    endproperty
    a_in_order: assert property (p_in_order) else $error("in order");

    property p_p_gain;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && (i_p_gain < $signed(`PFC_ZERO)) && (static_err == `PFC_ERR_P_GAIN) && !i_tune_start
         && r_ff.state == PFC_IDLE) |=> (o_err_code == `PFC_ERR_P_GAIN);
    endproperty
    a_p_gain: assert property (p_p_gain) else $error("p gain");

    property p_mode;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && (i_mode > 3'(PFC_MODE_PID)) && !i_clear && r_ff.state == PFC_IDLE && !i_tune_start)
        |=> (o_err_code != `PFC_ERR_NONE);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");

    property p_tune_dir;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && o_tuning && (i_dir_reverse != r_ff.tune_dir))
        |=> (o_err_code == `PFC_ERR_TUNE_DIR) && o_tune_err;
    endproperty
    a_tune_dir: assert property (p_tune_dir) else $error("tune dir");

    property p_side;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !o_tuning && !o_running && i_tune_start && side_bad)
        |=> (o_err_code == `PFC_ERR_SETPOINT_SIDE) && o_tune_err && o_tuning;
    endproperty
    a_side: assert property (p_side) else $error("setpoint side");

    property p_bounds;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && (o_tuning || o_running) && i_cycle
         && ((i_process_value > i_pv_max) || (i_process_value < i_pv_min)))
        |=> (o_warn_code == `PFC_WRN_IN_BOUNDS);
    endproperty
    a_bounds: assert property (p_bounds) else $error("pv bounds");

    property p_warn_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_cycle && !i_clear) |=> $stable(o_warn_code);
    endproperty
    a_warn_hold: assert property (p_warn_hold) else $error("warn hold");

    property p_clear;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && i_clear && !i_cycle && static_err == `PFC_ERR_NONE && !i_tune_start
         && !o_tuning) |=> (o_warn_code == `PFC_ERR_NONE) && (o_err_code == `PFC_ERR_NONE);
    endproperty
    a_clear: assert property (p_clear) else $error("clear");

    c_tune: cover property (@(posedge i_core_clk) disable iff (i_rst)
        o_tuning ##1 !o_tuning ##1 o_running);
    c_tune_err: cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_tune_err));
    c_high: cover property (@(posedge i_core_clk) disable iff (i_rst)
        o_warn_code == `PFC_WRN_OUT_HIGH);
    c_mix: cover property (@(posedge i_core_clk) disable iff (i_rst)
        o_err_code == `PFC_ERR_MIX_SV);

endmodule // pfc_checker

// [design/pfc_defs.svh]
// Constants for the loop fault checker
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
`define PFC_ERR_NONE 16'h0000
`define PFC_ERR_OUT_ORDER 16'h0001
`define PFC_ERR_IN_ORDER 16'h0002
`define PFC_ERR_OUT_PERIOD 16'h0003
`define PFC_ERR_SETPOINT_SIDE 16'h0004
`define PFC_ERR_PWM_POINT 16'h0005
`define PFC_ERR_P_GAIN 16'h0006
`define PFC_ERR_I_TIME 16'h0007
`define PFC_ERR_D_TIME 16'h0008
`define PFC_ERR_MODE 16'h0009
`define PFC_ERR_TUNE_DIR 16'h000A
`define PFC_ERR_LOOP_PERIOD 16'h000B
`define PFC_ERR_MIX_DIR 16'h000C
`define PFC_ERR_MIX_SV 16'h000D
`define PFC_WRN_IN_BOUNDS 16'h0001
`define PFC_WRN_CYCLE_SHORT 16'h0002
`define PFC_WRN_IN_SLEW 16'h0003
`define PFC_WRN_OUT_SLEW 16'h0004
`define PFC_WRN_OUT_HIGH 16'h0005
`define PFC_WRN_OUT_LOW 16'h0006
`define PFC_MIN_PERIOD 16'h0064
`define PFC_PWM_LO 8'h20
`define PFC_PWM_HI 8'h3F
`define PFC_ZERO 16'h0000
`endif

// [design/pfc_pkg.sv]
// Types for the loop fault checker
package pfc_pkg;
    typedef enum logic [1:0] {
        PFC_MODE_P = 2'b00,
        PFC_MODE_PI = 2'b01,
        PFC_MODE_PD = 2'b10,
        PFC_MODE_PID = 2'b11
    } pfc_mode_t;
    typedef enum logic [1:0] {
        PFC_IDLE = 2'b00,
        PFC_TUNING = 2'b01,
        PFC_RUNNING = 2'b10
    } pfc_state_t;
    typedef struct packed {
        pfc_state_t state;
        logic tune_dir;
        logic tune_err;
        logic [15:0] err_code;
        logic [15:0] warn_code;
        logic signed [15:0] prev_pv;
        logic prev_pv_ok;
    } pfc_regs_t;
endpackage

// [dv/pfc_checker_tb_top.sv]
// Self-checking bench for the loop fault checker
`timescale 1ns/100ps
module pfc_checker_tb_top;
    import pfc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic signed [15:0] i_mv_max, i_mv_min, i_pv_max, i_pv_min, i_p_gain, i_i_time, i_d_time;
    logic signed [15:0] i_set_value, i_partner_set_value, i_process_value, i_mv_calc, i_mv_prev;
    logic [15:0] i_out_period, i_op_period, i_scan_time, i_pv_slew_limit, i_mv_slew_limit;
    logic [7:0] i_pwm_point;
    logic [2:0] i_mode;
    logic i_pwm_en, i_dir_reverse, i_mixed, i_mixed_expect_reverse;
    logic i_cycle, i_tune_start, i_tune_done, i_run_start, i_stop, i_clear;
    logic [15:0] o_err_code, o_warn_code;
    logic o_tune_err, o_tuning, o_running;
    int fails = 0;
    int comparisons = 0;
    int codes [9] = '{1, 2, 5, 6, 7, 8, 9, 12, 13};

    always #10 i_core_clk = ~i_core_clk;

    pfc_checker dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_mv_max(i_mv_max), .i_mv_min(i_mv_min), .i_pv_max(i_pv_max), .i_pv_min(i_pv_min),
        .i_out_period(i_out_period), .i_op_period(i_op_period), .i_scan_time(i_scan_time),
        .i_pwm_en(i_pwm_en), .i_pwm_point(i_pwm_point), .i_p_gain(i_p_gain),
        .i_i_time(i_i_time), .i_d_time(i_d_time), .i_mode(i_mode),
        .i_dir_reverse(i_dir_reverse), .i_mixed(i_mixed),
        .i_mixed_expect_reverse(i_mixed_expect_reverse), .i_set_value(i_set_value),
        .i_partner_set_value(i_partner_set_value), .i_process_value(i_process_value),
        .i_pv_slew_limit(i_pv_slew_limit), .i_mv_slew_limit(i_mv_slew_limit),
        .i_mv_calc(i_mv_calc), .i_mv_prev(i_mv_prev), .i_cycle(i_cycle),
        .i_tune_start(i_tune_start), .i_tune_done(i_tune_done), .i_run_start(i_run_start),
        .i_stop(i_stop), .i_clear(i_clear), .o_err_code(o_err_code),
        .o_warn_code(o_warn_code), .o_tune_err(o_tune_err), .o_tuning(o_tuning),
        .o_running(o_running));

    ////////////////////////////////////////////////////////////////////////////////
    // Legal settings: PV above SV so a forward tuning start is clean
    task automatic defaults();
        i_mv_max = 16'h0FA0; i_mv_min = 16'h0000; i_pv_max = 16'h0FA0; i_pv_min = 16'h0000;
        i_out_period = 16'h0064; i_op_period = 16'h03E8; i_scan_time = 16'h0010;
        i_pwm_en = 1'b0; i_pwm_point = 8'h20; i_p_gain = 16'h0000; i_i_time = 16'h0000;
        i_d_time = 16'h0000; i_mode = 3'h3; i_dir_reverse = 1'b0; i_mixed = 1'b0;
        i_mixed_expect_reverse = 1'b0; i_set_value = 16'h03E8;
        i_partner_set_value = 16'h03E8; i_process_value = 16'h07D0;
        i_pv_slew_limit = 16'hFFFF; i_mv_slew_limit = 16'hFFFF;
        i_mv_calc = 16'h0100; i_mv_prev = 16'h0100;
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    task automatic chk_code(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic set_fault(input int k);
        case (k)
            1: i_mv_max = 16'hFFFF;
            2: i_pv_min = 16'h1000;
            3: begin i_pwm_en = 1'b1; i_out_period = 16'h0063; end
            5: begin i_pwm_en = 1'b1; i_pwm_point = 8'h40; end
            6: i_p_gain = 16'hFFFF;
            7: i_i_time = 16'h8000;
            8: i_d_time = 16'hFFFF;
            9: i_mode = 3'h4;
            11: i_op_period = 16'h0063;
            12: begin i_mixed = 1'b1; i_dir_reverse = 1'b1; end
            13: begin i_mixed = 1'b1; i_partner_set_value = 16'h03E9; end
            default: ;
        endcase
    endtask

    // One PID cycle end, then let the registered warning land
    task automatic cyc();
        i_cycle = 1'b1;
        step(1);
        i_cycle = 1'b0;
        step(1);
    endtask

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        defaults();
        {i_cycle, i_tune_start, i_tune_done, i_run_start, i_stop, i_clear} = 6'h00;
        repeat (4) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst = 1'b0;
        chk_code("err_code", 16'h0000, o_err_code);
        chk_flag("tune_err", 1'b0, o_tune_err);
        // Idle: each static fault except 3 and 11 alone, then auto-clear once removed
        foreach (codes[i]) begin
            set_fault(codes[i]);
            step(2);
            chk_code("err_code", codes[i][15:0], o_err_code);
            defaults();
            step(2);
            chk_code("err_code", 16'h0000, o_err_code);
        end
        i_pwm_en = 1'b1;
        i_pwm_point = 8'h1F;
        step(2);
        chk_code("err_code", 16'h0005, o_err_code);
        i_pwm_point = 8'h3F;
        step(2);
        chk_code("err_code", 16'h0000, o_err_code);
        // Mixed loop that is meant to run in reverse
        defaults();
        i_mixed = 1'b1;
        i_mixed_expect_reverse = 1'b1;
        step(2);
        chk_code("err_code", 16'h000C, o_err_code);
        i_dir_reverse = 1'b1;
        step(2);
        chk_code("err_code", 16'h0000, o_err_code);
        defaults();
        set_fault(3);
        set_fault(11);
        step(2);
        chk_code("err_code", 16'h0000, o_err_code);
        $display("test idle_errors done");
        // Running: period faults and the output period boundary
        defaults();
        i_run_start = 1'b1;
        step(1);
        i_run_start = 1'b0;
        step(1);
        chk_flag("running", 1'b1, o_running);
        set_fault(3);
        step(2);
        chk_code("err_code", 16'h0003, o_err_code);
        i_out_period = 16'h0064;
        step(2);
        chk_code("err_code", 16'h0000, o_err_code);
        defaults();
        set_fault(11);
        step(2);
        chk_code("err_code", 16'h000B, o_err_code);
        defaults();
        // Warnings, each alone, sampled only at the cycle end
        cyc();
        chk_code("warn_code", 16'h0000, o_warn_code);
        for (int w = 1; w <= 6; w++) begin
            case (w)
                1: i_process_value = 16'h1000;
                2: i_scan_time = 16'h03E8;
                3: begin i_process_value = 16'h0834; i_pv_slew_limit = 16'h0032; end
                4: begin i_mv_calc = 16'h0200; i_mv_slew_limit = 16'h0032; end
                5: begin i_mv_calc = 16'h0FA1; i_mv_prev = 16'h0FA0; end
                default: begin i_mv_calc = 16'hFFFF; i_mv_prev = 16'h0000; end
            endcase
            step(1);
            chk_code("warn_code", 16'h0000, o_warn_code);
            cyc();
            chk_code("warn_code", w[15:0], o_warn_code);
            defaults();
            step(3);
            chk_code("warn_code", w[15:0], o_warn_code);
            cyc();
        end
        i_process_value = 16'h1000;
        cyc();
        defaults();
        i_clear = 1'b1;
        step(1);
        i_clear = 1'b0;
        step(1);
        chk_code("warn_code", 16'h0000, o_warn_code);
        $display("test running_warnings done");
        // Tuning: wrong side at start, sticky until clear, direction change
        i_stop = 1'b1;
        step(1);
        i_stop = 1'b0;
        i_set_value = 16'h0800;
        i_tune_start = 1'b1;
        step(1);
        i_tune_start = 1'b0;
        i_run_start = 1'b1;
        step(1);
        i_run_start = 1'b0;
        i_set_value = 16'h03E8;
        step(2);
        chk_flag("tuning", 1'b1, o_tuning);
        chk_flag("running", 1'b0, o_running);
        chk_code("err_code", 16'h0004, o_err_code);
        chk_flag("tune_err", 1'b1, o_tune_err);
        i_clear = 1'b1;
        step(1);
        i_clear = 1'b0;
        step(1);
        chk_code("err_code", 16'h0000, o_err_code);
        chk_flag("tune_err", 1'b0, o_tune_err);
        i_mode = 3'h5;
        step(2);
        chk_flag("tune_err", 1'b1, o_tune_err);
        i_mode = 3'h3;
        i_dir_reverse = 1'b1;
        step(2);
        chk_code("err_code", 16'h000A, o_err_code);
        i_dir_reverse = 1'b0;
        step(2);
        chk_code("err_code", 16'h000A, o_err_code);
        i_tune_done = 1'b1;
        step(1);
        i_tune_done = 1'b0;
        // Tuned gains copied in before the loop is enabled
        i_p_gain = 16'h0010;
        i_i_time = 16'h0020;
        i_d_time = 16'h0005;
        i_run_start = 1'b1;
        step(1);
        i_run_start = 1'b0;
        chk_flag("tuning", 1'b0, o_tuning);
        chk_flag("running", 1'b1, o_running);
        chk_code("err_code", 16'h000A, o_err_code);
        // Reverse tuning faults when SV is below PV
        i_stop = 1'b1;
        step(1);
        i_stop = 1'b0;
        i_clear = 1'b1;
        i_dir_reverse = 1'b1;
        step(1);
        i_clear = 1'b0;
        i_tune_start = 1'b1;
        step(1);
        i_tune_start = 1'b0;
        step(1);
        chk_code("err_code", 16'h0004, o_err_code);
        chk_flag("tune_err", 1'b1, o_tune_err);
        $display("test tuning done");
        // Clock enable low freezes a pending clear
        i_ce = 1'b0;
        i_clear = 1'b1;
        step(2);
        chk_code("err_code", 16'h0004, o_err_code);
        chk_flag("tuning", 1'b1, o_tuning);
        i_ce = 1'b1;
        step(1);
        i_clear = 1'b0;
        chk_code("err_code", 16'h0000, o_err_code);
        chk_flag("tune_err", 1'b0, o_tune_err);
        // Reset while tuning, then a clean forward start at once
        i_rst = 1'b1;
        step(1);
        chk_flag("tuning", 1'b0, o_tuning);
        chk_code("err_code", 16'h0000, o_err_code);
        i_rst = 1'b0;
        i_dir_reverse = 1'b0;
        i_tune_start = 1'b1;
        step(1);
        i_tune_start = 1'b0;
        chk_flag("tuning", 1'b1, o_tuning);
        chk_code("err_code", 16'h0000, o_err_code);
        chk_flag("tune_err", 1'b0, o_tune_err);
        i_ce = 1'b0;
        i_stop = 1'b1;
        step(2);
        i_stop = 1'b0;
        i_ce = 1'b1;
        step(1);
        chk_flag("tuning", 1'b1, o_tuning);
        $display("test reset_and_enable done");
        summarize();
    end
endmodule // pfc_checker_tb_top
